// file: hw/rxos_stat_counters.sv
// receive checksum-offload statistics counters with ahb-lite register access
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - count good datagrams whose tcp payload checksum fails, at 0x23c.
// - count good datagrams with a good icmp payload, at 0x240.
// - count good datagrams whose icmp payload checksum fails, at 0x244.
// - add bytes of good ipv4 datagrams with tcp/udp/icmp at 0x250.
// - add ipv4 length field for header-error datagrams at 0x254.
// - add ipv4 length field for datagrams without known payload at 0x258.
// - add ipv4 length field for fragmented datagrams at 0x25c.
// - add udp bytes with checksum disabled at 0x260, no ip header.
// - add bytes of good ipv6 datagrams with tcp/udp/icmpv6 at 0x264.
// - add ipv6 length field for header-error datagrams at 0x268.
// - add ipv6 length field for datagrams without known payload at 0x26c.
// - add bytes of good udp segments at 0x270, no ip header.
// - add bytes of udp segments with checksum errors at 0x274.
// - add good tcp segment bytes at 0x278, bad ones at 0x27c.
// - add good icmp segment bytes at 0x280, bad ones at 0x284.
// - all counters are read-only and zero after reset.
// - preset with full-half 0 loads 0x7fff_f800 bytes, 0x7fff_fff0 frames.
// - preset with full-half 1 loads 0xffff_f800 bytes, 0xffff_fff0 frames.
// - preset trigger bit 4 loads counters and self-clears after one cycle.
// - freeze bit 3 stops event updates; clear-on-read still clears.
// - clear-on-read bit 2 zeroes a counter read through its low byte lane.
// - stop-rollover bit 1 holds a counter at maximum instead of wrapping.
// - global reset bit 0 clears all counters and self-clears after one cycle.
// - counter flag sets at half and at maximum; low-lane read clears it.
module rxos_stat_counters
   import rxos_pkg::*;
#(
   parameter int LEN_W = 16
) (
   input  wire logic                    i_clk,
   input  wire logic                    i_rst_n,
   input  wire logic                    i_hsel,
   input  wire logic [31:0]             i_haddr,
   input  wire logic [1:0]              i_htrans,
   input  wire logic                    i_hwrite,
   input  wire logic [2:0]              i_hsize,
   input  wire logic [31:0]             i_hwdata,
   input  wire logic                    i_hready,
   output logic                         o_hreadyout,
   output logic                         o_hresp,
   output logic [31:0]                  o_hrdata,
   input  wire logic [RXOS_NUM_CNT-1:0] i_cnt_evt,
   input  wire logic [LEN_W-1:0]        i_ip_len,
   input  wire logic [LEN_W-1:0]        i_seg_len,
   output logic [RXOS_NUM_CNT-1:0]      o_cnt_flags
);

   function automatic logic rxos_ofs_match(input logic [31:0] addr,
                                           input logic [11:0] ofs);
      return (addr[11:2] == ofs[11:2]);
   endfunction

   logic [31:0]             cnt_q [RXOS_NUM_CNT];
   logic [31:0]             cnt_d [RXOS_NUM_CNT];
   logic [RXOS_NUM_CNT-1:0] flag_q;
   logic [RXOS_NUM_CNT-1:0] flag_d;
   logic                    stop_roll_q;
   logic                    clr_on_rd_q;
   logic                    freeze_q;
   logic                    full_half_q;
   logic                    global_clr_q;
   logic                    preset_q;
   logic                    wr_pend_q;
   logic [31:0]             wr_addr_q;
   logic                    wr_lane0_q;
   logic [31:0]             hrdata_q;

   // ---- bus address phase decode ----
   wire                     ap_take;
   wire                     rd_take;
   wire                     wr_take;
   wire                     lane0_cov;
   wire                     wr_ctrl;
   wire [RXOS_NUM_CNT-1:0]  addr_hit;
   wire [RXOS_NUM_CNT-1:0]  rd_low_hit;
   wire [31:0]              ctrl_view;
   wire [31:0]              rd_or [RXOS_NUM_CNT+1];

   assign ap_take = i_hsel && i_hready && (i_htrans == RXOS_HTRANS_NONSEQ || i_htrans[1]);
   assign rd_take = ap_take && !i_hwrite;
   assign wr_take = ap_take && i_hwrite;
   // low lane covered by word, low half or byte 0
   assign lane0_cov = (i_hsize == RXOS_HSIZE_BYTE) ? (i_haddr[1:0] == 2'h0) :
                      (i_hsize == RXOS_HSIZE_HALF) ? !i_haddr[1] : 1'b1;
   assign wr_ctrl = wr_pend_q && wr_lane0_q
                    && rxos_ofs_match(wr_addr_q, RXOS_OFS_STAT_COUNTER_CONTROL);

   assign ctrl_view = {26'h0, full_half_q, preset_q, freeze_q, clr_on_rd_q,
                       stop_roll_q, global_clr_q};
   assign rd_or[0] =
      (rxos_ofs_match(i_haddr, RXOS_OFS_STAT_COUNTER_CONTROL) ? ctrl_view : 32'h0) |
      (rxos_ofs_match(i_haddr, RXOS_OFS_COUNTER_FLAGS) ?
       {{(32-RXOS_NUM_CNT){1'b0}}, flag_q} : 32'h0);

   // ---- per-counter datapath ----
   genvar gi;
   generate
      for (gi = 0; gi < RXOS_NUM_CNT; gi = gi + 1) begin : g_cnt
         wire [31:0] amt;
         wire [31:0] base;
         wire [32:0] sum;
         wire [31:0] inc;
         wire [31:0] preset_val;
         wire        bump;
         wire        rd_clr;
         wire        hit_half;
         wire        hit_max;

         assign addr_hit[gi]   = rxos_ofs_match(i_haddr, RXOS_CNT_OFS[gi]);
         assign rd_low_hit[gi] = rd_take && addr_hit[gi] && lane0_cov;
         assign rd_or[gi+1]    = rd_or[gi] | (addr_hit[gi] ? cnt_q[gi] : 32'h0);

         // ip-level counters take the length field
         // segment counters exclude ip header bytes
         if (gi < RXOS_NUM_FRM) begin : g_frm
            assign amt        = 32'h0000_0001;
            assign preset_val = full_half_q ? RXOS_PRESET_FRM_FULL : RXOS_PRESET_FRM_HALF;
         end else begin : g_byte
            assign amt        = RXOS_SEG_LEN_MASK[gi] ?
                                {{(32-LEN_W){1'b0}}, i_seg_len} :
                                {{(32-LEN_W){1'b0}}, i_ip_len};
            assign preset_val = full_half_q ? RXOS_PRESET_BYTE_FULL : RXOS_PRESET_BYTE_HALF;
         end

         // freeze blocks events only, not the clear-on-read
         assign bump   = i_cnt_evt[gi] && !freeze_q;
         // read returns old value, counter restarts from zero
         assign rd_clr = rd_low_hit[gi] && clr_on_rd_q;
         assign base   = rd_clr ? RXOS_CNT_RESET : cnt_q[gi];
         assign sum    = {1'b0, base} + {1'b0, amt};
         // saturate on carry when stop-rollover is set
         assign inc    = (sum[32] && stop_roll_q) ? RXOS_CNT_MAX : sum[31:0];

         // global clear beats preset, both beat events
         assign cnt_d[gi] = global_clr_q ? RXOS_CNT_RESET :
                            preset_q     ? preset_val :
                            bump         ? inc : base;

         // half crossing, reaching or passing all-ones
         assign hit_half   = bump && !base[31] && inc[31];
         assign hit_max    = bump && ((inc == RXOS_CNT_MAX && base != RXOS_CNT_MAX) || sum[32]);
         // a new hit wins over a clearing read in the same cycle
         assign flag_d[gi] = hit_half || hit_max || (flag_q[gi] && !rd_low_hit[gi]);

         always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               cnt_q[gi] <= RXOS_CNT_RESET;
            end else begin
               cnt_q[gi] <= cnt_d[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flag_q <= '0;
      end else begin
         flag_q <= flag_d;
      end
   end

   // ---- control register, written in the data phase ----
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stop_roll_q <= 1'b0;
         clr_on_rd_q <= 1'b0;
         freeze_q    <= 1'b0;
         full_half_q <= 1'b0;
      end else if (wr_ctrl) begin
         stop_roll_q <= i_hwdata[RXOS_CTRL_STOP_ROLL];
         clr_on_rd_q <= i_hwdata[RXOS_CTRL_CLR_ON_RD];
         freeze_q    <= i_hwdata[RXOS_CTRL_FREEZE];
         full_half_q <= i_hwdata[RXOS_CTRL_FULL_HALF];
      end
   end

   // trigger bits live exactly one cycle
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         global_clr_q <= 1'b0;
         preset_q     <= 1'b0;
      end else begin
         global_clr_q <= wr_ctrl && i_hwdata[RXOS_CTRL_GLOBAL_CLR];
         preset_q     <= wr_ctrl && i_hwdata[RXOS_CTRL_PRESET];
      end
   end

   // ---- bus phase tracking and read data ----
   // read data is sampled at the address edge so the clearing read still
   // returns the pre-clear value with zero wait states
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_pend_q  <= 1'b0;
         wr_addr_q  <= 32'h0;
         wr_lane0_q <= 1'b0;
         hrdata_q   <= 32'h0;
      end else begin
         wr_pend_q  <= wr_take;
         wr_addr_q  <= wr_take ? i_haddr : wr_addr_q;
         wr_lane0_q <= wr_take && lane0_cov;
         hrdata_q   <= rd_take ? rd_or[RXOS_NUM_CNT] : 32'h0;
      end
   end

   assign o_hreadyout = 1'b1;
   assign o_hresp     = 1'b0;
   assign o_hrdata    = hrdata_q;
   assign o_cnt_flags = flag_q;

endmodule
`default_nettype wire

// file: pkg/rxos_pkg.sv
// constants for the receive checksum-offload statistics counters
`default_nettype none
package rxos_pkg;

   localparam int RXOS_NUM_CNT = 17;
   // counters below this index count datagrams, the rest count bytes
   localparam int RXOS_NUM_FRM = 3;

   localparam logic [11:0] RXOS_OFS_STAT_COUNTER_CONTROL      = 12'h100;
   localparam logic [11:0] RXOS_OFS_COUNTER_FLAGS             = 12'h208;
   localparam logic [11:0] RXOS_OFS_RX_TCP_BAD_CHECKSUM_DGRAM = 12'h23c;
   localparam logic [11:0] RXOS_OFS_RX_ICMP_GOOD_DGRAM        = 12'h240;
   localparam logic [11:0] RXOS_OFS_RX_ICMP_BAD_CHECKSUM_DGRAM = 12'h244;
   localparam logic [11:0] RXOS_OFS_RX_V4_GOOD_BYTE           = 12'h250;
   localparam logic [11:0] RXOS_OFS_RX_V4_HEADER_FAULT_BYTE   = 12'h254;
   localparam logic [11:0] RXOS_OFS_RX_V4_NO_PAYLOAD_BYTE     = 12'h258;
   localparam logic [11:0] RXOS_OFS_RX_V4_FRAGMENT_BYTE       = 12'h25c;
   localparam logic [11:0] RXOS_OFS_RX_UDP_CHECKSUM_OFF_BYTE  = 12'h260;
   localparam logic [11:0] RXOS_OFS_RX_V6_GOOD_BYTE           = 12'h264;
   localparam logic [11:0] RXOS_OFS_RX_V6_HEADER_FAULT_BYTE   = 12'h268;
   localparam logic [11:0] RXOS_OFS_RX_V6_NO_PAYLOAD_BYTE     = 12'h26c;
   localparam logic [11:0] RXOS_OFS_RX_UDP_GOOD_BYTE          = 12'h270;
   localparam logic [11:0] RXOS_OFS_RX_UDP_BAD_BYTE           = 12'h274;
   localparam logic [11:0] RXOS_OFS_RX_TCP_GOOD_BYTE          = 12'h278;
   localparam logic [11:0] RXOS_OFS_RX_TCP_BAD_BYTE           = 12'h27c;
   localparam logic [11:0] RXOS_OFS_RX_ICMP_GOOD_BYTE         = 12'h280;
   localparam logic [11:0] RXOS_OFS_RX_ICMP_BAD_BYTE          = 12'h284;

   // counter index order: event bit i of the event port feeds counter i
   localparam logic [11:0] RXOS_CNT_OFS [RXOS_NUM_CNT] = '{
      RXOS_OFS_RX_TCP_BAD_CHECKSUM_DGRAM, RXOS_OFS_RX_ICMP_GOOD_DGRAM,
      RXOS_OFS_RX_ICMP_BAD_CHECKSUM_DGRAM, RXOS_OFS_RX_V4_GOOD_BYTE,
      RXOS_OFS_RX_V4_HEADER_FAULT_BYTE, RXOS_OFS_RX_V4_NO_PAYLOAD_BYTE,
      RXOS_OFS_RX_V4_FRAGMENT_BYTE, RXOS_OFS_RX_UDP_CHECKSUM_OFF_BYTE,
      RXOS_OFS_RX_V6_GOOD_BYTE, RXOS_OFS_RX_V6_HEADER_FAULT_BYTE,
      RXOS_OFS_RX_V6_NO_PAYLOAD_BYTE, RXOS_OFS_RX_UDP_GOOD_BYTE,
      RXOS_OFS_RX_UDP_BAD_BYTE, RXOS_OFS_RX_TCP_GOOD_BYTE,
      RXOS_OFS_RX_TCP_BAD_BYTE, RXOS_OFS_RX_ICMP_GOOD_BYTE,
      RXOS_OFS_RX_ICMP_BAD_BYTE};

   // byte counters fed by segment length rather than the ip length field
   localparam logic [RXOS_NUM_CNT-1:0] RXOS_SEG_LEN_MASK = 17'h1f880;

   localparam int RXOS_CTRL_GLOBAL_CLR = 0;
   localparam int RXOS_CTRL_STOP_ROLL  = 1;
   localparam int RXOS_CTRL_CLR_ON_RD  = 2;
   localparam int RXOS_CTRL_FREEZE     = 3;
   localparam int RXOS_CTRL_PRESET     = 4;
   localparam int RXOS_CTRL_FULL_HALF  = 5;

   localparam logic [31:0] RXOS_CNT_RESET        = 32'h0000_0000;
   localparam logic [31:0] RXOS_CNT_MAX          = 32'hffff_ffff;
   localparam logic [31:0] RXOS_PRESET_BYTE_HALF = 32'h7fff_f800;
   localparam logic [31:0] RXOS_PRESET_FRM_HALF  = 32'h7fff_fff0;
   localparam logic [31:0] RXOS_PRESET_BYTE_FULL = 32'hffff_f800;
   localparam logic [31:0] RXOS_PRESET_FRM_FULL  = 32'hffff_fff0;

   localparam logic [1:0] RXOS_HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] RXOS_HSIZE_BYTE    = 3'h0;
   localparam logic [2:0] RXOS_HSIZE_HALF    = 3'h1;

endpackage
`default_nettype wire

// file: sim/rxos_monitor.sv
// checker on the counter block's ports
`timescale 1ns/1ps
`default_nettype none
module rxos_monitor
   import rxos_pkg::*;
(
   input wire logic        i_clk,
   input wire logic        i_rst_n,
   input wire logic        i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0]  i_htrans,
   input wire logic        i_hwrite,
   input wire logic [2:0]  i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic        i_hready,
   input wire logic        o_hreadyout,
   input wire logic        o_hresp,
   input wire logic [31:0] o_hrdata,
   input wire logic [16:0] i_cnt_evt,
   input wire logic [16:0] o_cnt_flags
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   wire logic rd = i_hsel & i_hready & i_htrans[1] & ~i_hwrite;
   wire logic wr = i_hsel & i_hready & i_htrans[1] & i_hwrite;
   wire logic at_ctl = i_haddr[11:2] == RXOS_OFS_STAT_COUNTER_CONTROL[11:2];
   wire logic at_c0 = i_haddr[11:2] == RXOS_OFS_RX_TCP_BAD_CHECKSUM_DGRAM[11:2];
   // data phase must be quiet, else a second write races the readback
   sequence s_ctl_wr;
      wr && at_ctl ##1 !(wr || rd);
   endsequence
   sequence s_ctl_rd;
      rd && at_ctl;
   endsequence
   a_ready_high: assert property (o_hreadyout) else $error("ready low");
   a_resp_okay: assert property (!o_hresp) else $error("error response");
   a_rdata_idle: assert property (!rd |=> o_hrdata == 32'h0) else $error("stray rdata");
   a_hole_zero: assert property (rd && i_haddr[11:0] == 12'h248 |=> o_hrdata == 32'h0)
      else $error("reserved not zero");
   a_ctl_back: assert property (s_ctl_wr ##1 !(wr || rd) ##1 s_ctl_rd |=>
      {o_hrdata[5], o_hrdata[3:1]} == {$past(i_hwdata[5], 3), $past(i_hwdata[3:1], 3)})
      else $error("control readback");
   a_flag_cause: assert property ((o_cnt_flags & ~$past(o_cnt_flags) & ~$past(i_cnt_evt))
      == 17'h0) else $error("flag without event");
   a_flag_clr: assert property (|($past(o_cnt_flags) & ~o_cnt_flags) |-> $past(rd))
      else $error("flag cleared without read");
   a_lane_clear: assert property (rd && at_c0 && i_hsize == 3'h2 && !i_cnt_evt[0]
      |=> !o_cnt_flags[0]) else $error("flag kept after read");
endmodule
bind rxos_stat_counters rxos_monitor u_mon (.i_clk, .i_rst_n, .i_hsel, .i_haddr, .i_htrans,
   .i_hwrite, .i_hsize, .i_hwdata, .i_hready, .o_hreadyout, .o_hresp, .o_hrdata,
   .i_cnt_evt, .o_cnt_flags);
`default_nettype wire

// file: sim/rxos_rx_model.sv
// receive path and checksum engine stand-in, one event per cycle of i_sel
`timescale 1ns/1ps
`default_nettype none
module rxos_rx_model (
   input wire logic        i_clk,
   input wire logic        i_rst_n,
   input wire logic [16:0] i_sel,
   input wire logic [15:0] i_len,
   output logic [16:0]     o_evt,
   output logic [15:0]     o_ip_len,
   output logic [15:0]     o_seg_len
);
   // lengths toggle between events so stale values never look valid
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_evt <= 17'h0;
         o_ip_len <= 16'h0;
         o_seg_len <= 16'h0;
      end else begin
         o_evt <= i_sel;
         o_ip_len <= (|i_sel) ? i_len : ~o_ip_len;
         o_seg_len <= (|i_sel) ? (i_len >> 1) : ~o_seg_len;
      end
   end
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// self-checking bench for the receive statistics counters
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import rxos_pkg::*;
   logic i_clk, i_rst_n, hsel, hwrite, rdy, resp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [16:0] sel, evt, flg;
   logic [15:0] len, ipl, sgl;
   int err_count, n_compared;
   rxos_rx_model rx_u (.i_clk, .i_rst_n, .i_sel(sel), .i_len(len), .o_evt(evt),
      .o_ip_len(ipl), .o_seg_len(sgl));
   rxos_stat_counters dut_u (.i_clk, .i_rst_n, .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
      .i_hready(rdy), .o_hreadyout(rdy), .o_hresp(resp), .o_hrdata(hrdata),
      .i_cnt_evt(evt), .i_ip_len(ipl), .i_seg_len(sgl), .o_cnt_flags(flg));
   always #12.5 i_clk = ~i_clk;
   task close_out;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] d);
      @(posedge i_clk);
      hsel <= 1'b1; htrans <= RXOS_HTRANS_NONSEQ; haddr <= {20'h0, a}; hwrite <= w;
      do @(posedge i_clk); while (rdy !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
      do @(posedge i_clk); while (rdy !== 1'b1);
      d = hrdata;
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] d;
      bus(1'b0, a, 32'h0, d);
      chk(d, e);
   endtask
   task automatic wc(input logic [11:0] a, input logic [31:0] v);
      logic [31:0] d;
      bus(1'b1, a, v, d);
   endtask
   task automatic ev(input logic [16:0] s, input logic [15:0] l, input int n);
      @(posedge i_clk);
      sel <= s; len <= l;
      repeat (n) @(posedge i_clk);
      sel <= 17'h0;
      repeat (2) @(posedge i_clk);
   endtask
   task automatic t_reset;
      for (int i = 0; i < 17; i++) rc(RXOS_CNT_OFS[i], 32'h0);
      wc(12'h23c, 32'hffff_ffff);
      rc(12'h23c, 32'h0);
      rc(12'h100, 32'h0);
      rc(12'h248, 32'h0);
   endtask
   // two back-to-back events per counter, length odd on even indices to expose halving
   task automatic t_count;
      logic [15:0] l;
      for (int i = 0; i < 17; i++) begin
         l = 16'h0101 + 16'(i * 17);
         ev(17'h1 << i, l, 2);
         rc(RXOS_CNT_OFS[i], i < 3 ? 32'h2 : (RXOS_SEG_LEN_MASK[i] ? 32'(l >> 1) << 1
            : 32'(l) << 1));
      end
   endtask
   task automatic t_preset(input logic fh);
      wc(12'h100, {26'h0, fh, 5'h10});
      rc(12'h100, {26'h0, fh, 5'h0});
      for (int i = 0; i < 17; i++)
         rc(RXOS_CNT_OFS[i], {fh, 31'h7fff_f800} | (i < 3 ? 32'h7f0 : 32'h0));
      // half crossing from the almost-half preset
      if (!fh) begin
         ev(17'h2, 16'h1, 16);
         chk({31'h0, flg[1]}, 32'h1);
         rc(12'h240, 32'h8000_0000);
         chk({31'h0, flg[1]}, 32'h0);
      end
   endtask
   task automatic t_limits;
      wc(12'h100, 32'h2);
      ev(17'h8, 16'h0900, 1);
      chk({31'h0, flg[3]}, 32'h1);
      rc(12'h250, 32'hffff_ffff);
      ev(17'h1, 16'h1, 17);
      chk({31'h0, flg[0]}, 32'h1);
      rc(12'h23c, 32'hffff_ffff);
      chk({31'h0, flg[0]}, 32'h0);
      wc(12'h100, 32'hc);
      ev(17'h20, 16'h40, 2);
      rc(12'h258, 32'hffff_f800);
      rc(12'h258, 32'h0);
      wc(12'h100, 32'h1);
      rc(12'h100, 32'h0);
      for (int i = 0; i < 17; i++) rc(RXOS_CNT_OFS[i], 32'h0);
   endtask
   initial begin
      i_clk = 1'b0; i_rst_n = 1'b0; hsel = 1'b0; hwrite = 1'b0; haddr = 32'h0;
      htrans = 2'h0; hsize = RXOS_HSIZE_BYTE + 3'h2; hwdata = 32'h0; sel = 17'h0; len = 16'h0;
      repeat (12) @(posedge i_clk);
      i_rst_n <= 1'b1;
      t_reset;
      t_count;
      t_preset(1'b0);
      t_preset(1'b1);
      t_limits;
      close_out;
   end
   initial begin
      repeat (20000) @(posedge i_clk);
      err_count++;
      close_out;
   end
endmodule
`default_nettype wire
